// >>> design/fp_exception_rounding_logic.sv
// Floating-point exception flags, interrupt gating, issue stall,
// rounding and special-operand results for 64-bit operations.
// Assumes all inputs come from logic on clk; one operation per cycle.
// Functional notes
// - Interrupt only if enable set when flag sets.
// - Enabling after a flag is set gives nothing.
// - Mode-changing instruction stalls issue until units idle.
// - Operations finish with the modes they started with.
// - Six exception flags kept in readable status.
// - Invalid for sNaN and impossible infinity or zero forms.
// - Ordered compare with NaN sets invalid, unordered.
// - Divide-by-zero for finite nonzero over zero.
// - Overflow gives infinity or largest finite by direction.
// - Overflow result ignores interrupt enable; no wrap.
// - Underflow gives signed zero and sets flag.
// - Overflow always sets inexact; underflow sets it only when a discarded bit is set.
// - Infinite or NaN operand sets exceptional input.
// - Guard below LSB, sticky ORs lower bits.
// - Exact when guard and sticky clear, else inexact.
// - Nearest rounds on guard with sticky or odd LSB.
// - Round-to-zero never increments.
// - Round-up increments positive inexact results only.
// - Round-down increments negative inexact results only.
// - Adding opposite-signed infinities yields NaN.
// - Subtracting opposite-signed infinities gives minuend infinity.
// - Square root special results for sign, zero, NaN.
// - Two mode bits select nearest, up, zero, down.
// - Mode change only affects later-issued operations.
//
// The address-and-strobe port and the address map are this design's own decisions.
`timescale 1ns/1ps
`include "fp_exc_consts.svh"
module fp_exception_rounding_logic #(
	parameter int ADDR_W = 4
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic mode_chg_req,
	input wire logic fu_busy,
	output logic fp_issue_stall,
	input wire logic op_valid,
	input wire fp_exc_pkg::op_e op_code,
	input wire logic [63:0] opnd_j,
	input wire logic [63:0] opnd_k,
	input wire logic pre_sign,
	input wire logic [10:0] pre_exp,
	input wire logic [51:0] pre_coef,
	input wire logic [`EXT_W-1:0] pre_ext,
	input wire logic pre_ovf,
	input wire logic pre_unf,
	output logic res_valid,
	output logic [63:0] res_value,
	output logic cmp_true,
	output logic cmp_unordered,
	output logic [`FLAG_W-1:0] op_flags,
	output logic fp_int_req
);
	import fp_exc_pkg::*;

	typedef struct packed {
		logic [`FLAG_W-1:0] status;
		logic [`FLAG_W-1:0] int_en;
		round_mode_e rmode;
		logic irq;
		logic stall;
		logic [31:0] rdata;
		logic res_valid;
		logic [63:0] res;
		logic cmp_true;
		logic cmp_unord;
		logic [`FLAG_W-1:0] flags;
	} state_s;

	state_s st_q;
	state_s st_d;
	round_if rif();

	fp_round_unit u_round (
		.rif(rif)
	);

	////////////////////////////////////////////////////////////////////
	// Operand classification.
	logic [10:0] ej;
	logic [10:0] ek;
	logic sj, sk;
	logic zj, zk, ij, ik, nj, nk, snj, snk;
	assign ej = opnd_j[`EXP_HI:`EXP_LO];
	assign ek = opnd_k[`EXP_HI:`EXP_LO];
	assign sj = opnd_j[`SIGN_B];
	assign sk = opnd_k[`SIGN_B];
	assign zj = ej == `EXP_ZERO;
	assign zk = ek == `EXP_ZERO;
	assign ij = ej == `EXP_MAX && opnd_j[`COEF_HI:0] == `COEF_ZERO;
	assign ik = ek == `EXP_MAX && opnd_k[`COEF_HI:0] == `COEF_ZERO;
	assign nj = ej == `EXP_MAX && opnd_j[`COEF_HI:0] != `COEF_ZERO;
	assign nk = ek == `EXP_MAX && opnd_k[`COEF_HI:0] != `COEF_ZERO;
	// Clear top coefficient bit marks a signalling NaN.
	assign snj = nj & ~opnd_j[`COEF_HI];
	assign snk = nk & ~opnd_k[`COEF_HI];

	// Quiet a NaN operand and force its sign positive.
	function automatic logic [63:0] quiet(input logic [63:0] x);
		logic [63:0] y;
		y = x;
		y[`SIGN_B] = 1'b0;
		y[`COEF_HI] = 1'b1;
		return y;
	endfunction : quiet

	// NaN made inside a unit, carrying the unit's tag.
	function automatic logic [63:0] gen_nan(input logic [2:0] tag);
		logic [63:0] y;
		y = `NAN_GEN;
		y[`TAG_LO+2:`TAG_LO] = tag;
		return y;
	endfunction : gen_nan

	// Signed infinity and signed zero words.
	function automatic logic [63:0] inf_w(input logic s);
		return {s, `EXP_MAX, `COEF_ZERO};
	endfunction : inf_w

	function automatic logic [63:0] zero_w(input logic s);
		return {s, `EXP_ZERO, `COEF_ZERO};
	endfunction : zero_w

	////////////////////////////////////////////////////////////////////
	// Rounding of the unit's pre-rounded result, under the current mode.
	logic [62:0] mag_rnd;
	logic rnd_ovf;
	logic away;
	assign rif.sign = pre_sign;
	assign rif.lsb = pre_coef[0];
	assign rif.ext = pre_ext;
	// Mode sampled on the taking edge only, so later writes do not reach it.
	assign rif.mode = st_q.rmode;
	assign mag_rnd = {pre_exp, pre_coef} + {62'h0, rif.inc};
	assign rnd_ovf = pre_ovf | (mag_rnd[62:`EXP_LO] == `EXP_MAX);
	// Whether the active mode rounds this sign away from zero.
	always_comb begin
		case (st_q.rmode)
			RM_NEAREST: away = 1'b1;
			RM_UP: away = ~pre_sign;
			RM_DOWN: away = pre_sign;
			default: away = 1'b0;
		endcase
	end

	// Signed ordering compare; zeros of either sign are equal.
	logic lt_jk;
	logic eq_jk;
	logic [62:0] mj, mk;
	assign mj = zj ? 63'h0 : opnd_j[62:0];
	assign mk = zk ? 63'h0 : opnd_k[62:0];
	assign eq_jk = (mj == mk) && (sj == sk || mj == 63'h0);
	always_comb begin
		if (eq_jk) begin
			lt_jk = 1'b0;
		end else if (sj != sk) begin
			lt_jk = sj;
		end else if (sj) begin
			lt_jk = mj > mk;
		end else begin
			lt_jk = mj < mk;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Result and flags of the operation taken this cycle.
	logic [63:0] r;
	logic [`FLAG_W-1:0] f;
	logic ct;
	logic cu;
	always_comb begin
		r = 64'h0000_0000_0000_0000;
		f = `FLAGS_NONE;
		ct = 1'b0;
		cu = 1'b0;
		f[`FL_XI] = ij | ik | nj | nk;
		f[`FL_INV] = snj | snk;
		case (op_code)
			OP_CMP_GT, OP_CMP_LT, OP_CMP_GE, OP_CMP_LE: begin
				if (nj | nk) begin
					f[`FL_INV] = 1'b1;
					cu = 1'b1;
				end else if (op_code == OP_CMP_GT) begin
					ct = ~lt_jk & ~eq_jk;
				end else if (op_code == OP_CMP_LT) begin
					ct = lt_jk;
				end else if (op_code == OP_CMP_GE) begin
					ct = ~lt_jk;
				end else begin
					ct = lt_jk | eq_jk;
				end
			end
			default: begin
				if (nj | nk) begin
					// Divide and square root give the default NaN; else signalling NaN first, else the j operand.
					if (op_code == OP_DIV || op_code == OP_SQRT) begin
						r = {1'b0, `EXP_MAX, `COEF_ONES};
					end else if (nj && (snj || !snk)) begin
						r = quiet(opnd_j);
					end else begin
						r = quiet(opnd_k);
					end
				end else if (op_code == OP_ADD && ij && ik) begin
					if (sj != sk) begin
						r = gen_nan(`TAG_ADD);
						f[`FL_INV] = 1'b1;
					end else begin
						r = inf_w(sj);
					end
				end else if (op_code == OP_SUB && ij && ik) begin
					if (sj != sk) begin
						r = inf_w(sj);
					end else begin
						r = gen_nan(`TAG_ADD);
						f[`FL_INV] = 1'b1;
					end
				end else if ((op_code == OP_ADD || op_code == OP_SUB) &&
					(ij || ik)) begin
					r = ij ? inf_w(sj) : inf_w(sk ^ (op_code == OP_SUB));
				end else if (op_code == OP_MUL && ((zj && ik) || (ij && zk))) begin
					r = gen_nan(`TAG_MUL);
					f[`FL_INV] = 1'b1;
				end else if (op_code == OP_MUL && (ij || ik)) begin
					r = inf_w(sj ^ sk);
				end else if (op_code == OP_MUL && (zj || zk)) begin
					r = zero_w(sj ^ sk);
				end else if (op_code == OP_DIV && ((zj && zk) || (ij && ik))) begin
					r = gen_nan(`TAG_DIV);
					f[`FL_INV] = 1'b1;
				end else if (op_code == OP_DIV && (ij || zk)) begin
					r = inf_w(sj ^ sk);
					f[`FL_DVZ] = zk & ~ij;
				end else if (op_code == OP_DIV && (zj || ik)) begin
					r = zero_w(sj ^ sk);
				end else if (op_code == OP_SQRT && zj) begin
					r = zero_w(sj);
				end else if (op_code == OP_SQRT && sj) begin
					r = gen_nan(`TAG_SQRT);
					f[`FL_INV] = 1'b1;
				end else if (op_code == OP_SQRT && ij) begin
					r = inf_w(1'b0);
				end else if (pre_unf) begin
					r = zero_w(pre_sign);
					f[`FL_UNF] = 1'b1;
					f[`FL_NX] = rif.inexact;
				end else if (rnd_ovf) begin
					// Choice never looks at the interrupt enables.
					r = away ? inf_w(pre_sign) :
						{pre_sign, `EXP_LARGEST, `COEF_ONES};
					f[`FL_OVF] = 1'b1;
					f[`FL_NX] = 1'b1;
				end else begin
					r = {pre_sign, mag_rnd};
					f[`FL_NX] = rif.inexact;
				end
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////
	// Next state: registers, sticky flags, interrupt gating and stall.
	logic [`FLAG_W-1:0] set_v;
	logic [`FLAG_W-1:0] clr_v;
	logic st_wr, en_wr, rm_wr;
	assign st_wr = reg_wr && reg_addr == `REG_STATUS;
	assign en_wr = reg_wr && reg_addr == `REG_INT_EN;
	assign rm_wr = reg_wr && reg_addr == `REG_RMODE;
	assign set_v = op_valid ? f : `FLAGS_NONE;
	assign clr_v = st_wr ? reg_wdata[`FLAG_W-1:0] : `FLAGS_NONE;

	always_comb begin
		st_d = st_q;
		// Write one to clear; a new event in the same cycle wins.
		st_d.status = (st_q.status & ~clr_v) | set_v;
		if (en_wr) begin
			st_d.int_en = reg_wdata[`FLAG_W-1:0];
		end
		if (rm_wr) begin
			st_d.rmode = round_mode_e'(reg_wdata[`RM_W-1:0]);
		end
		// Only a fresh flag with its enable already on requests service.
		if (|(set_v & ~st_q.status & st_q.int_en)) begin
			st_d.irq = 1'b1;
		end else if (st_wr) begin
			st_d.irq = 1'b0;
		end
		if (mode_chg_req) begin
			st_d.stall = 1'b1;
		end else if (!fu_busy && !op_valid) begin
			st_d.stall = 1'b0;
		end
		st_d.res_valid = op_valid;
		if (op_valid) begin
			st_d.res = r;
			st_d.cmp_true = ct;
			st_d.cmp_unord = cu;
			st_d.flags = f;
		end
		// Read data stand only in the cycle after the strobe.
		st_d.rdata = `RDATA_ZERO;
		if (reg_rd && reg_addr == `REG_STATUS) begin
			st_d.rdata[`FLAG_W-1:0] = st_q.status;
		end else if (reg_rd && reg_addr == `REG_INT_EN) begin
			st_d.rdata[`FLAG_W-1:0] = st_q.int_en;
		end else if (reg_rd && reg_addr == `REG_RMODE) begin
			st_d.rdata[`RM_W-1:0] = st_q.rmode;
		end
	end

	// State register.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	// Outputs.
	assign reg_rdata = st_q.rdata;
	assign fp_issue_stall = st_q.stall | mode_chg_req;
	assign res_valid = st_q.res_valid;
	assign res_value = st_q.res;
	assign cmp_true = st_q.cmp_true;
	assign cmp_unordered = st_q.cmp_unord;
	assign op_flags = st_q.flags;
	assign fp_int_req = st_q.irq;

	////////////////////////////////////////////////////////////////////
	// Checks.
	sequence s_new_enabled;
		op_valid && |(f & ~st_q.status & st_q.int_en);
	endsequence

	property p_irq_set;
		@(posedge clk) disable iff (sys_rst) s_new_enabled |=> fp_int_req;
	endproperty
	a_irq_set: assert property (p_irq_set)
		else $error("enabled new flag gave no interrupt");

	property p_no_late_irq;
		@(posedge clk) disable iff (sys_rst)
			!fp_int_req && !(op_valid && |(f & ~st_q.status & st_q.int_en))
			|=> !fp_int_req;
	endproperty
	a_no_late_irq: assert property (p_no_late_irq)
		else $error("interrupt without a fresh enabled flag");

	property p_stall_hold;
		@(posedge clk) disable iff (sys_rst)
			mode_chg_req ##1 fu_busy [*2] |-> fp_issue_stall;
	endproperty
	a_stall_hold: assert property (p_stall_hold)
		else $error("issue not stalled while units busy");

	property p_sticky;
		@(posedge clk) disable iff (sys_rst)
			st_q.status[`FL_INV] && !st_wr |=> st_q.status[`FL_INV];
	endproperty
	a_sticky: assert property (p_sticky)
		else $error("invalid flag dropped without clear");

	property p_flag_accum;
		@(posedge clk) disable iff (sys_rst)
			op_valid && f[`FL_NX] |=> st_q.status[`FL_NX] && op_flags[`FL_NX];
	endproperty
	a_flag_accum: assert property (p_flag_accum)
		else $error("inexact not recorded");

	property p_unf_zero;
		@(posedge clk) disable iff (sys_rst)
			op_valid && f[`FL_UNF] |=>
			res_value[`EXP_HI:0] == {`EXP_ZERO, `COEF_ZERO};
	endproperty
	a_unf_zero: assert property (p_unf_zero)
		else $error("underflow result not zero");

	property p_ovf_result;
		@(posedge clk) disable iff (sys_rst)
			op_valid && f[`FL_OVF] |=> op_flags[`FL_NX] &&
			(res_value[`EXP_HI:`EXP_LO] == `EXP_MAX ||
			res_value[`EXP_HI:0] == {`EXP_LARGEST, `COEF_ONES});
	endproperty
	a_ovf_result: assert property (p_ovf_result)
		else $error("overflow result not infinity or largest");

	property p_cmp_nan;
		@(posedge clk) disable iff (sys_rst)
			op_valid && op_code == OP_CMP_LT && (nj || nk) |=>
			cmp_unordered && !cmp_true && op_flags[`FL_INV];
	endproperty
	a_cmp_nan: assert property (p_cmp_nan)
		else $error("compare with NaN not unordered invalid");

	property p_rz_no_inc;
		@(posedge clk) disable iff (sys_rst)
			st_q.rmode == RM_ZERO |-> !rif.inc;
	endproperty
	a_rz_no_inc: assert property (p_rz_no_inc)
		else $error("round to zero incremented");

	property p_xi;
		@(posedge clk) disable iff (sys_rst)
			op_valid && (ij || nk) |=> op_flags[`FL_XI] && st_q.status[`FL_XI];
	endproperty
	a_xi: assert property (p_xi)
		else $error("exceptional input not flagged");
endmodule : fp_exception_rounding_logic

// >>> design/fp_exc_consts.svh
// Constants for the floating-point exception and rounding block.
// Assumes inclusion by bare name from the package and the design files.
`ifndef FP_EXC_CONSTS_SVH
`define FP_EXC_CONSTS_SVH

// Register indices on the plain register port.
`define REG_STATUS 4'h0
`define REG_INT_EN 4'h1
`define REG_RMODE 4'h2

// Flag positions in the status and enable registers.
`define FLAG_W 6
`define FL_INV 0
`define FL_DVZ 1
`define FL_OVF 2
`define FL_UNF 3
`define FL_NX 4
`define FL_XI 5
`define RM_W 2

// Word layout.
`define SIGN_B 63
`define EXP_HI 62
`define EXP_LO 52
`define COEF_HI 51
`define EXT_W 10
`define EXP_MAX 11'h7ff
`define EXP_LARGEST 11'h7fe
`define EXP_ZERO 11'h000
`define COEF_ZERO 52'h0_0000_0000_0000
`define COEF_ONES 52'hf_ffff_ffff_ffff
`define FLAGS_NONE 6'h00
`define RDATA_ZERO 32'h0000_0000

// Tags in bits 50..48 of NaNs made inside a unit.
`define TAG_ADD 3'h1
`define TAG_MUL 3'h2
`define TAG_DIV 3'h4
`define TAG_SQRT 3'h5
`define NAN_GEN 64'hfff8_ffff_ffff_ffff
`define TAG_LO 48

`endif

// >>> design/fp_exc_pkg.sv
// Types shared by the floating-point exception and rounding block.
// Assumes the constants header is on the include path.
`include "fp_exc_consts.svh"
package fp_exc_pkg;
	// Rounding mode: low bit is round_mode_bit_low, high is round_mode_bit_high.
	typedef enum logic [1:0] {
		RM_NEAREST = 2'b00,
		RM_UP = 2'b01,
		RM_ZERO = 2'b10,
		RM_DOWN = 2'b11
	} round_mode_e;

	// Operation presented with its operands.
	typedef enum logic [3:0] {
		OP_ADD = 4'b0000,
		OP_SUB = 4'b0001,
		OP_MUL = 4'b0010,
		OP_DIV = 4'b0011,
		OP_SQRT = 4'b0100,
		OP_CMP_GT = 4'b0101,
		OP_CMP_LT = 4'b0110,
		OP_CMP_GE = 4'b0111,
		OP_CMP_LE = 4'b1000
	} op_e;
endpackage : fp_exc_pkg

// >>> design/round_if.sv
// Carrier between the exception core and its rounding decision unit.
// Assumes both ends run on the same clock; the path is combinational.
`timescale 1ns/1ps
`include "fp_exc_consts.svh"
interface round_if;
	logic sign;
	logic lsb;
	logic [`EXT_W-1:0] ext;
	fp_exc_pkg::round_mode_e mode;
	logic inc;
	logic inexact;
	modport core(output sign, output lsb, output ext, output mode,
		input inc, input inexact);
	modport unit(input sign, input lsb, input ext, input mode,
		output inc, output inexact);
endinterface : round_if

// >>> design/fp_round_unit.sv
// Rounding decision: guard, sticky and the LSB increment per mode.
// Assumes the core supplies the bits below the coefficient LSB.
`timescale 1ns/1ps
`include "fp_exc_consts.svh"
module fp_round_unit (
	round_if.unit rif
);
	import fp_exc_pkg::*;

	logic guard;
	logic sticky;

	// Guard is the bit just below the LSB; sticky ORs all lower bits.
	assign guard = rif.ext[`EXT_W-1];
	assign sticky = |rif.ext[`EXT_W-2:0];

	// Inexact whenever any discarded bit is set.
	assign rif.inexact = guard | sticky;

	// Increment decision by mode.
	always_comb begin
		case (rif.mode)
			RM_NEAREST: rif.inc = guard & (sticky | rif.lsb);
			RM_ZERO: rif.inc = 1'b0;
			RM_UP: rif.inc = ~rif.sign & (guard | sticky);
			RM_DOWN: rif.inc = rif.sign & (guard | sticky);
			default: rif.inc = 1'b0;
		endcase
	end
endmodule : fp_round_unit

// >>> dv/fu_model.sv
// Behavioural model of the floating-point units beside the block.
// Assumes one clock; each taken operation keeps a unit busy lat cycles.
`timescale 1ns/1ps
module fu_model (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic op_valid,
	input wire logic [3:0] lat,
	output logic fu_busy
);
	logic [3:0] cnt_q;

	////////////////////////////////////////////////////////////////////////
	// Load the longest pending latency, then drain one unit per cycle.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			cnt_q <= 4'h0;
		end else if (op_valid && lat > cnt_q) begin
			cnt_q <= lat;
		end else if (cnt_q != 4'h0) begin
			cnt_q <= cnt_q - 4'h1;
		end
	end

	// Busy while any work remains in the pipe.
	assign fu_busy = cnt_q != 4'h0;
endmodule : fu_model

// >>> dv/testbench.sv
// Self-checking bench for the exception and rounding block.
// Assumes the design package and the unit model are compiled first.
`timescale 1ns/1ps
module testbench;
	import fp_exc_pkg::*;
	typedef struct packed {
		logic [63:0] v;
		logic [5:0] f;
		logic cmp;
		logic ct;
		logic cu;
	} exp_s;
	typedef struct packed {
		op_e o;
		logic [63:0] j;
		logic [63:0] k;
		logic [63:0] v;
		logic [5:0] f;
	} case_s;
	localparam logic [63:0] INF = 64'h7ff0_0000_0000_0000;
	localparam logic [63:0] NINF = 64'hfff0_0000_0000_0000;
	localparam logic [63:0] QN = 64'h7ff8_0000_0000_0000;
	localparam logic [63:0] SN = 64'h7ff0_0000_0000_0001;
	localparam logic [63:0] ONE = 64'h3ff0_0000_0000_0000;
	localparam logic [63:0] TWO = 64'h4000_0000_0000_0000;
	localparam logic [63:0] NEG = 64'hbff0_0000_0000_0000;
	localparam logic [63:0] NZ = 64'h8000_0000_0000_0000;
	localparam logic [63:0] Z = 64'h0000_0000_0000_0000;
	localparam logic [63:0] GA = 64'hfff9_ffff_ffff_ffff;
	localparam logic [63:0] GM = 64'hfffa_ffff_ffff_ffff;
	localparam logic [63:0] GD = 64'hfffc_ffff_ffff_ffff;
	localparam logic [63:0] GS = 64'hfffd_ffff_ffff_ffff;
	localparam logic [63:0] DN = 64'h7fff_ffff_ffff_ffff;
	localparam case_s CASES [14] = '{
		'{OP_ADD, INF, NINF, GA, 6'h21}, '{OP_SUB, INF, NINF, INF, 6'h20},
		'{OP_SUB, NINF, INF, NINF, 6'h20}, '{OP_SUB, INF, INF, GA, 6'h21},
		'{OP_MUL, Z, INF, GM, 6'h21}, '{OP_DIV, Z, Z, GD, 6'h01},
		'{OP_DIV, INF, INF, GD, 6'h21}, '{OP_DIV, ONE, Z, INF, 6'h02},
		'{OP_SQRT, NEG, Z, GS, 6'h01}, '{OP_SQRT, NZ, Z, NZ, 6'h00},
		'{OP_SQRT, QN, Z, DN, 6'h20},
		'{OP_ADD, SN, QN, 64'h7ff8_0000_0000_0001, 6'h21},
		'{OP_MUL, ONE, QN, QN, 6'h20}, '{OP_DIV, QN, ONE, DN, 6'h20}};
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [3:0] reg_addr = 4'h0;
	logic [31:0] reg_wdata = 32'h0000_0000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic mode_chg_req = 1'b0;
	logic op_valid = 1'b0;
	op_e op_code = OP_ADD;
	logic [63:0] opnd_j = 64'h0000_0000_0000_0000;
	logic [63:0] opnd_k = 64'h0000_0000_0000_0000;
	logic pre_sign = 1'b0;
	logic [10:0] pre_exp = 11'h000;
	logic [51:0] pre_coef = 52'h0_0000_0000_0000;
	logic [9:0] pre_ext = 10'h000;
	logic pre_ovf = 1'b0;
	logic pre_unf = 1'b0;
	logic [3:0] lat = 4'h3;
	logic [31:0] reg_rdata;
	logic fp_issue_stall, res_valid, cmp_true, cmp_unordered;
	logic fp_int_req, fu_busy;
	logic [63:0] res_value;
	logic [5:0] op_flags, acc;
	logic n_wr, n_rd, n_op, s, g, t, aw;
	logic rd_pend = 1'b0;
	logic [3:0] n_a;
	logic [31:0] n_d;
	logic [9:0] x;
	logic [51:0] c;
	logic [10:0] pe;
	logic [1:0] um;
	logic [63:0] v;
	exp_s me;
	exp_s eq[$];
	logic [31:0] rq[$];
	int mismatches = 0;
	int samples_checked = 0;
	int seed = 21802;

	fp_exception_rounding_logic #(.ADDR_W(4)) DUT (.clk(clk),
		.sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.mode_chg_req(mode_chg_req), .fu_busy(fu_busy),
		.fp_issue_stall(fp_issue_stall), .op_valid(op_valid),
		.op_code(op_code), .opnd_j(opnd_j), .opnd_k(opnd_k),
		.pre_sign(pre_sign), .pre_exp(pre_exp), .pre_coef(pre_coef),
		.pre_ext(pre_ext), .pre_ovf(pre_ovf), .pre_unf(pre_unf),
		.res_valid(res_valid), .res_value(res_value),
		.cmp_true(cmp_true), .cmp_unordered(cmp_unordered),
		.op_flags(op_flags), .fp_int_req(fp_int_req));
	fu_model units (.clk(clk), .sys_rst(sys_rst), .op_valid(op_valid),
		.lat(lat), .fu_busy(fu_busy));

	// Free-running core clock.
	always #50 clk = ~clk;

	////////////////////////////////////////////////////////////////////////
	// Comparison and closing tasks.
	task check_v(input logic [63:0] got, input logic [63:0] ex);
		samples_checked++;
		if (got !== ex) begin
			mismatches++;
			$display("ERROR %0t value %h expected %h", $time, got, ex);
		end
	endtask : check_v

	task check_b(input logic got, input logic ex);
		samples_checked++;
		if (got !== ex) begin
			mismatches++;
			$display("ERROR %0t bit %b expected %b", $time, got, ex);
		end
	endtask : check_b

	task test_done;
		$display("mismatches %0d samples_checked %0d", mismatches,
			samples_checked);
		if (mismatches == 0 && samples_checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : test_done

	// Increment decision per mode, sign, guard, sticky and LSB.
	function automatic logic rinc(input logic [1:0] m, input logic sg,
		input logic gd, input logic st, input logic lb);
		case (m)
			2'b00: return gd & (st | lb);
			2'b01: return !sg & (gd | st);
			2'b10: return 1'b0;
			default: return sg & (gd | st);
		endcase
	endfunction : rinc

	////////////////////////////////////////////////////////////////////////
	// Drivers: requests are staged, then launched together by tick.
	task tick;
		reg_wr <= n_wr;
		reg_rd <= n_rd;
		reg_addr <= n_a;
		reg_wdata <= n_d;
		op_valid <= n_op;
		n_wr = 1'b0;
		n_rd = 1'b0;
		n_op = 1'b0;
		@(posedge clk);
	endtask : tick

	// For a read, d is the expected read data.
	task put_reg(input logic w, input logic [3:0] a, input logic [31:0] d);
		n_wr = w;
		n_rd = !w;
		n_a = a;
		n_d = d;
		if (!w) rq.push_back(d);
	endtask : put_reg

	task put_op(input op_e o, input logic [63:0] j, input logic [63:0] k,
		input logic ps, input logic [10:0] e, input logic [51:0] cf,
		input logic [9:0] xt, input logic po, input logic pu,
		input exp_s ex);
		op_code <= o;
		opnd_j <= j;
		opnd_k <= k;
		pre_sign <= ps;
		pre_exp <= e;
		pre_coef <= cf;
		pre_ext <= xt;
		pre_ovf <= po;
		pre_unf <= pu;
		n_op = 1'b1;
		eq.push_back(ex);
		acc = acc | ex.f;
	endtask : put_op

	task sp(input int i);
		put_op(CASES[i].o, CASES[i].j, CASES[i].k, 1'b0, 11'h000,
			52'h0_0000_0000_0000, 10'h000, 1'b0, 1'b0,
			exp_s'{CASES[i].v, CASES[i].f, 1'b0, 1'b0, 1'b0});
		tick;
	endtask : sp

	task rw(input logic w, input logic [3:0] a, input logic [31:0] d);
		put_reg(w, a, d);
		tick;
	endtask : rw

	////////////////////////////////////////////////////////////////////////
	// Result watcher: takes the oldest note whenever a result shows.
	always @(posedge clk) begin
		if (!sys_rst && res_valid === 1'b1) begin
			me = eq.pop_front();
			check_v(64'(op_flags), 64'(me.f));
			if (me.cmp) begin
				check_b(cmp_true, me.ct);
				check_b(cmp_unordered, me.cu);
			end else begin
				check_v(res_value, me.v);
			end
		end
		if (rd_pend) begin
			check_v(64'(reg_rdata), 64'(rq.pop_front()));
		end else if (!sys_rst) begin
			check_v(64'(reg_rdata), 64'h0000_0000_0000_0000);
		end
		rd_pend = !sys_rst && reg_rd === 1'b1;
	end

	// Watchdog against a hang.
	initial begin
		#2000000;
		mismatches++;
		test_done;
	end

	////////////////////////////////////////////////////////////////////////
	// Main sequence.
	initial begin
		{n_wr, n_rd, n_op, acc, um} = '0;
		repeat (16) @(posedge clk);
		sys_rst <= 1'b0;
		// Reset values, unmapped place, back to back.
		rw(1'b0, 4'h0, 32'h0000_0000);
		rw(1'b0, 4'h1, 32'h0000_0000);
		rw(1'b0, 4'h2, 32'h0000_0000);
		rw(1'b1, 4'h3, 32'h0000_0003);
		rw(1'b0, 4'h3, 32'h0000_0000);
		// A pending flag enabled later raises nothing.
		sp(5);
		rw(1'b1, 4'h1, 32'h0000_0001);
		rw(1'b0, 4'h0, 32'h0000_0001);
		check_b(fp_int_req, 1'b0);
		rw(1'b1, 4'h0, 32'h0000_003f);
		acc = 6'h00;
		rw(1'b0, 4'h0, 32'h0000_0000);
		// Samples at the edge see the values of the cycle just ended.
		sp(8);
		sp(12);
		check_b(fp_int_req, 1'b1);
		rw(1'b0, 4'h0, 32'h0000_0021);
		rw(1'b1, 4'h0, 32'h0000_003f);
		acc = 6'h00;
		rw(1'b0, 4'h0, 32'h0000_0000);
		check_b(fp_int_req, 1'b0);
		// Special operands, back to back.
		for (int i = 0; i < 14; i++) sp(i);
		// Ordered compares with a NaN, then one real ordering.
		for (int i = 0; i < 4; i++) begin
			put_op(op_e'(5 + i), ONE, QN, 1'b0, 11'h000,
				52'h0_0000_0000_0000, 10'h000, 1'b0, 1'b0,
				exp_s'{Z, 6'h21, 1'b1, 1'b0, 1'b1});
			tick;
		end
		put_op(OP_CMP_GT, TWO, ONE, 1'b0, 11'h000, 52'h0_0000_0000_0000,
			10'h000, 1'b0, 1'b0, exp_s'{Z, 6'h00, 1'b1, 1'b1, 1'b0});
		tick;
		// Rounding; a mode write beside an op leaves that op unchanged.
		for (int m = 0; m < 4; m++) begin
			for (int n = 0; n < 8; n++) begin
				s = 1'($random(seed));
				x = {n[1], n[0] ? 9'({$random(seed)} % 511 + 1) : 9'h000};
				c = {1'b0, 51'({$random(seed), $random(seed)})};
				c[0] = n[2];
				pe = {1'b0, 10'($random(seed))} | 11'h001;
				g = x[9];
				t = |x[8:0];
				if (n == 0) put_reg(1'b1, 4'h2, 32'(m));
				v = {s, pe, c + 52'(rinc(um, s, g, t, c[0]))};
				put_op(OP_MUL, ONE, ONE, s, pe, c, x, 1'b0, 1'b0,
					exp_s'{v, (g | t) ? 6'h10 : 6'h00, 1'b0, 1'b0,
					1'b0});
				tick;
				um = 2'(m);
			end
		end
		// Overflow and underflow in every mode, interrupts enabled.
		rw(1'b1, 4'h1, 32'h0000_003f);
		for (int m = 0; m < 4; m++) begin
			rw(1'b1, 4'h2, 32'(m));
			for (int i = 0; i < 4; i++) begin
				s = i[0];
				x = 10'($random(seed));
				g = x[9] | (|x[8:0]);
				aw = m == 0 || (m == 1 && !s) || (m == 3 && s);
				v = aw ? {s, INF[62:0]} : {s, 11'h7fe, 52'hf_ffff_ffff_ffff};
				if (i[1]) v = {s, 63'h0};
				put_op(OP_MUL, ONE, ONE, s, 11'h400, 52'h8_0000_0000_0000, x,
					!i[1], i[1], exp_s'{v, i[1] ? (g ? 6'h18 : 6'h08) : 6'h14,
					1'b0, 1'b0, 1'b0});
				tick;
			end
		end
		// Issue stall across a mode change while a unit drains.
		lat <= 4'(3 + {$random(seed)} % 6);
		sp(12);
		// Drop the strobe so that this op is taken once only.
		op_valid <= 1'b0;
		mode_chg_req <= 1'b1;
		#1 check_b(fp_issue_stall, 1'b1);
		@(posedge clk);
		mode_chg_req <= 1'b0;
		#1;
		for (int i = 0; i < 12 && fu_busy === 1'b1; i++) begin
			check_b(fp_issue_stall, 1'b1);
			@(posedge clk);
			#1;
		end
		check_b(fp_issue_stall, 1'b1);
		@(posedge clk);
		#1 check_b(fp_issue_stall, 1'b0);
		tick;
		// Every flag raised since the last clear is still recorded.
		rw(1'b0, 4'h0, 32'(acc));
		repeat (2) tick;
		check_b(eq.size() == 0, 1'b1);
		test_done;
	end
endmodule : testbench
